//--- tswd_pkg.sv
// Package of constants for the two-stage watchdog timer
`default_nettype none
package tswd_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_PRELOAD1 = 6'h00; // First preload value
  localparam logic [5:0] OFS_PRELOAD2 = 6'h04; // Second preload value
  localparam logic [5:0] OFS_CONFIG = 6'h08; // Config register
  localparam logic [5:0] OFS_UNLOCK = 6'h0c; // Unlock key port
  localparam logic [5:0] OFS_LOCK = 6'h10; // Lock register
  localparam logic [5:0] OFS_KICK = 6'h14; // Reload register
  localparam logic [5:0] OFS_STATUS = 6'h18; // Sticky event status
  localparam logic [5:0] OFS_MASK = 6'h1c; // Interrupt mask
  localparam logic [5:0] OFS_COUNT = 6'h20; // Live count, low 32 bits
  // Unlock key bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'h80;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h86;
  // Field positions
  localparam int CFG_PRESCALE_BIT = 2; // 0: about 1 MHz, 1: about 1 kHz
  localparam int CFG_OUT_EN_BIT = 5; // Fault pin output enable
  localparam int LOCK_LOCK_BIT = 0; // Lock until main reset
  localparam int LOCK_ENABLE_BIT = 1; // Timer enable
  localparam int LOCK_TOGGLE_BIT = 2; // 1: fault output toggles per expiry
  localparam int KICK_BIT = 8; // Reload request bit
  localparam int STS_STAGE1_BIT = 0; // First-stage expiry event
  localparam int STS_STAGE2_BIT = 1; // Second-stage expiry event
  // Widths and reset values
  localparam int CNT_W = 35;
  localparam logic [CNT_W-1:0] PRELOAD_RST = 35'h0000fffff;
  // Timing: watchdog base clock and tick periods
  localparam int WD_CLK_NS = 30; // 33 MHz base period
  localparam int SYS_CLK_NS = 5; // 200 MHz system clock
  localparam int BASE_DIV = WD_CLK_NS / SYS_CLK_NS; // Sys cycles per base tick
  localparam int US_NS = 1020; // About 1 us tick, 34 base ticks
  localparam int MS_NS = 1044480; // About 1 ms tick, 34816 base ticks
  localparam int US_DIV = US_NS / WD_CLK_NS; // Base ticks per fast tick
  localparam int MS_DIV = MS_NS / WD_CLK_NS; // Base ticks per slow tick
  // Stage machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STAGE1 = 2'b01,
    ST_STAGE2 = 2'b10
  } tswd_state_e;
endpackage : tswd_pkg
`default_nettype wire

//--- tswd_top.sv
// Two-stage watchdog timer with Avalon-MM register slave
// How it works
// - Prescaler picks about 1 us or 1 ms ticks
// - 35-bit down-counter steps on each selected tick
// - Enable loads first preload, starts stage one
// - Stage one reaching zero raises internal interrupt
// - Then load second preload, count stage two
// - Stage two expiry drives fault high, sets flag
// - Lock config bit: hold high or toggle
// - Preload writes accepted only after unlock pair
// - New preload used only at next stage entry
// - Completed reload sequence restarts stage one with first preload
// - Ticks derive from 33 MHz 30 ns base
// - Expiry flag survives main reset, cleared by hard
// - Fault pin driven only when config bit 5
// - Disabled at reset; lock blocks disabling

// Register map, byte offsets on the Avalon-MM slave
//   00h first preload, 04h second preload, 32 bits, top 3 count bits zero
//   08h config: bit 2 slow tick, bit 5 fault pin output enable
//   0ch unlock port, write only, takes the two key bytes on lane 0
//   10h lock: bit 0 lock, bit 1 enable, bit 2 toggle mode
//   14h reload: bit 8 restarts the first stage
//   18h status: bit 0 stage one, bit 1 stage two, read clears
//   18h status bit 2: expiry flag, read only, kept in the always-on well
//   1ch interrupt mask, same layout as status bits 1:0
//   20h live count, low 32 bits
// Every access waits exactly one cycle before it is answered.
// Lock only freezes config and lock; the enable stays as written.
// After a second-stage expiry the timer starts over in stage one.
`timescale 1ns/1ps
`default_nettype none
module tswd_top
  import tswd_pkg::*;
#(
  parameter int MS_DIV_P = MS_DIV // Base ticks per slow tick, shortenable
) (
  input wire logic sys_clk,
  input wire logic rstn, // Main reset, synchronous, active low
  input wire logic hard_rstn, // Always-on well reset, synchronous, active low
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic fault_output_pin,
  output logic fault_output_pin_oe
);

  // Register state
  logic [CNT_W-1:0] preload1_ff, nxt_preload1; // First preload
  logic [CNT_W-1:0] preload2_ff, nxt_preload2; // Second preload
  logic [7:0] config_ff, nxt_config; // Config register
  logic [2:0] lock_ff, nxt_lock; // Lock register
  logic [1:0] unlock_ff, nxt_unlock; // 0 none, 1 first key, 2 unlocked
  logic [1:0] status_ff, nxt_status; // Sticky events
  logic [1:0] mask_ff, nxt_mask; // Interrupt mask
  logic [31:0] rdata_ff, nxt_rdata; // Read data
  logic ack_ff, nxt_ack; // Answer cycle
  // Timer state
  tswd_state_e state_ff, nxt_state; // Stage
  logic [CNT_W-1:0] cnt_ff, nxt_cnt; // Down-counter
  logic [2:0] base_ff, nxt_base; // Sys to 30 ns divider
  logic [15:0] pre_ff, nxt_pre; // Base to tick divider
  logic fault_ff, nxt_fault; // Fault level
  logic expired_ff, nxt_expired; // Always-on expiry flag
  // Decoded bus strobes, prescaler ticks and the enable
  logic wr, rd, kick, base_tick, tick, enable;

  // A request is answered one cycle after it is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr = avs_write & ~ack_ff;
  assign rd = avs_read & ~ack_ff;
  assign enable = lock_ff[LOCK_ENABLE_BIT];
  assign avs_readdata = rdata_ff;
  // Level interrupt while any unmasked event is pending
  assign irq = |(status_ff & mask_ff);
  // The pin is driven only while its output enable is set
  assign fault_output_pin = fault_ff & config_ff[CFG_OUT_EN_BIT];
  assign fault_output_pin_oe = config_ff[CFG_OUT_EN_BIT];
  // Kick only counts in the unlocked state
  assign kick = wr & (avs_address == OFS_KICK) & (unlock_ff == 2'd2)
                & avs_writedata[KICK_BIT] & avs_byteenable[1];

  // Prescaler from 200 MHz down to the 30 ns base, then to the tick
  always_comb begin
    nxt_base = base_ff;
    nxt_pre = pre_ff;
    base_tick = 1'b0;
    tick = 1'b0;
    // Six system clocks make one base tick of the 33 MHz timebase
    if (base_ff == 3'(BASE_DIV - 1)) begin
      nxt_base = 3'd0;
      base_tick = 1'b1;
    end else begin
      nxt_base = base_ff + 3'd1;
    end
    // Restart the tick phase while idle or on a kick,
    // so a reload always buys one full tick
    if (!enable || state_ff == ST_IDLE || kick) begin
      nxt_pre = 16'd0;
    end else if (base_tick) begin
      // Config bit 2 picks the slow or the fast tick
      if (pre_ff == (config_ff[CFG_PRESCALE_BIT] ? 16'(MS_DIV_P - 1) : 16'(US_DIV - 1))) begin
        nxt_pre = 16'd0;
        tick = 1'b1;
      end else begin
        nxt_pre = pre_ff + 16'd1;
      end
    end
  end

  // Register writes, unlock tracking, reads
  always_comb begin
    nxt_preload1 = preload1_ff;
    nxt_preload2 = preload2_ff;
    nxt_config = config_ff;
    nxt_lock = lock_ff;
    nxt_unlock = unlock_ff;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    nxt_rdata = rdata_ff;
    // Ack pulses one cycle after a request is first seen
    nxt_ack = (avs_read | avs_write) & ~ack_ff;
    if (wr) begin
      // Any write other than the next key ends the unlock window
      nxt_unlock = 2'd0;
      case (avs_address)
        // First key opens, second key right after it unlocks
        OFS_UNLOCK: begin
          if (avs_byteenable[0] && avs_writedata[7:0] == UNLOCK_KEY1) begin
            nxt_unlock = 2'd1;
          end else if (avs_byteenable[0] && unlock_ff == 2'd1
                       && avs_writedata[7:0] == UNLOCK_KEY2) begin
            nxt_unlock = 2'd2;
          end
        end
        // Preloads land only when unlocked; the running count is untouched
        OFS_PRELOAD1: begin
          if (unlock_ff == 2'd2) begin
            nxt_preload1 = {3'd0, avs_writedata};
          end
        end
        // Second preload is used at the next stage two entry
        OFS_PRELOAD2: begin
          if (unlock_ff == 2'd2) begin
            nxt_preload2 = {3'd0, avs_writedata};
          end
        end
        // Config refuses writes once the lock bit is set
        OFS_CONFIG: begin
          if (!lock_ff[LOCK_LOCK_BIT] && avs_byteenable[0]) begin
            nxt_config = avs_writedata[7:0];
          end
        end
        // Lock bit 0 also guards itself until reset
        OFS_LOCK: begin
          if (!lock_ff[LOCK_LOCK_BIT] && avs_byteenable[0]) begin
            nxt_lock = avs_writedata[2:0];
          end
        end
        // Mask is never locked
        OFS_MASK: begin
          if (avs_byteenable[0]) begin
            nxt_mask = avs_writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Read data is captured at the end of the wait cycle and held until the next read
    if (rd) begin
      case (avs_address)
        OFS_PRELOAD1: nxt_rdata = preload1_ff[31:0];
        OFS_PRELOAD2: nxt_rdata = preload2_ff[31:0];
        OFS_CONFIG: nxt_rdata = {24'd0, config_ff};
        OFS_LOCK: nxt_rdata = {29'd0, lock_ff};
        OFS_STATUS: nxt_rdata = {29'd0, expired_ff, status_ff};
        OFS_MASK: nxt_rdata = {30'd0, mask_ff};
        OFS_COUNT: nxt_rdata = cnt_ff[31:0];
        default: nxt_rdata = 32'h0000_0000;
      endcase
      // Status read clears the stage events; the expiry flag stays
      if (avs_address == OFS_STATUS) begin
        nxt_status = 2'd0; // Read clears
      end
    end
    // Events set after the clear so a same-cycle event wins
    if (tick && cnt_ff == '0 && state_ff == ST_STAGE1 && !kick) begin
      nxt_status[STS_STAGE1_BIT] = 1'b1;
    end
    // Stage two expiry is recorded the same way
    if (tick && cnt_ff == '0 && state_ff == ST_STAGE2 && !kick) begin
      nxt_status[STS_STAGE2_BIT] = 1'b1;
    end
  end

  // Stage machine and down-counter
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_fault = fault_ff;
    nxt_expired = expired_ff;
    // Stage sequencing
    case (state_ff)
      // Enabling loads the first preload
      ST_IDLE: begin
        if (enable) begin
          nxt_state = ST_STAGE1;
          nxt_cnt = preload1_ff;
        end
      end
      // Both stages count the same way
      ST_STAGE1, ST_STAGE2: begin
        // Disabling wins over a kick or a tick
        if (!enable) begin
          nxt_state = ST_IDLE;
        end else if (kick) begin
          // Reload restarts the first stage
          nxt_state = ST_STAGE1;
          nxt_cnt = preload1_ff;
        // Each tick steps the count; zero at a tick ends the stage
        end else if (tick) begin
          // Count down while above zero
          if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 35'd1;
          // Stage one over: interrupt, then stage two
          end else if (state_ff == ST_STAGE1) begin
            nxt_state = ST_STAGE2;
            nxt_cnt = preload2_ff;
          end else begin
            nxt_state = ST_STAGE1;
            nxt_cnt = preload1_ff;
            nxt_expired = 1'b1;
            // Hold high, or invert on each later expiry
            nxt_fault = lock_ff[LOCK_TOGGLE_BIT] ? ~fault_ff : 1'b1;
          end
        end
      end
      // Unused code falls back to idle
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Main-well registers
  always_ff @(posedge sys_clk) begin
    // Main reset returns every main-well register to its default
    if (!rstn) begin
      preload1_ff <= PRELOAD_RST;
      preload2_ff <= PRELOAD_RST;
      config_ff <= 8'h00;
      lock_ff <= 3'd0;
      unlock_ff <= 2'd0;
      status_ff <= 2'd0;
      mask_ff <= 2'd0;
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      base_ff <= 3'd0;
      pre_ff <= 16'd0;
      fault_ff <= 1'b0;
    end else if (clk_en) begin
      preload1_ff <= nxt_preload1;
      preload2_ff <= nxt_preload2;
      config_ff <= nxt_config;
      lock_ff <= nxt_lock;
      unlock_ff <= nxt_unlock;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      base_ff <= nxt_base;
      pre_ff <= nxt_pre;
      fault_ff <= nxt_fault;
    end
  end

  // Always-on well flag, only the hard reset clears it
  always_ff @(posedge sys_clk) begin
    if (!hard_rstn) begin
      expired_ff <= 1'b0;
    end else if (clk_en) begin
      expired_ff <= nxt_expired;
    end
  end

endmodule : tswd_top
`default_nettype wire

//--- tswd_props.sv
// Checker of the watchdog port behaviour
`timescale 1ns/1ps
`default_nettype none
module tswd_props
  import tswd_pkg::*;
#(parameter int MS_DIV_P = 4) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hard_rstn,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic fault_output_pin,
  input wire logic fault_output_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Released pin never shows a fault
  property p_pin_oe; !fault_output_pin_oe |-> !fault_output_pin; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin high while released");
  // Pin enable moves only on a config write
  property p_oe_src;
    $changed(fault_output_pin_oe) |-> $past(avs_write) && $past(avs_address) == OFS_CONFIG;
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("pin enable moved unasked");
  // Leaving reset: pin released, no interrupt
  property p_rst_quiet; $rose(rstn) |-> !fault_output_pin_oe && !irq; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet after reset");
  // Status read drops the interrupt
  property p_rd_clear;
    avs_read && avs_address == OFS_STATUS && !avs_waitrequest |=> !irq;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("irq kept after status read");
  // First cycle of a request always waits
  property p_wait_first; $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  // Answer comes one cycle later
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer late");
  // Idle bus never stalls and the last read data stands
  property p_idle;
    !avs_read && !avs_write |-> !avs_waitrequest && $stable(avs_readdata);
  endproperty
  a_idle: assert property (p_idle) else $error("stall while idle");
  // Unmapped reads return zero
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > OFS_COUNT |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_irq: cover property ($rose(irq));
  c_fault: cover property ($rose(fault_output_pin));
  c_status: cover property (avs_read && avs_address == OFS_STATUS && !avs_waitrequest);
endmodule : tswd_props
bind tswd_top tswd_props #(.MS_DIV_P(MS_DIV_P)) tswd_props_i (
  .sys_clk(sys_clk), .rstn(rstn), .hard_rstn(hard_rstn), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .fault_output_pin(fault_output_pin), .fault_output_pin_oe(fault_output_pin_oe));
`default_nettype wire

//--- tswd_fault_mon.sv
// Board-side monitor of the fault pin
`timescale 1ns/1ps
`default_nettype none
module tswd_fault_mon (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fault_output_pin,
  input wire logic fault_output_pin_oe,
  output logic line_lvl,
  output logic [7:0] rise_cnt_ff
);
  logic last_ff; // Line level one cycle ago
  // Board pull-down holds a released line low
  assign line_lvl = fault_output_pin_oe ? fault_output_pin : 1'b0;
  // Count fault assertions seen on the line
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      last_ff <= 1'b0;
      rise_cnt_ff <= 8'h00;
    end else begin
      last_ff <= line_lvl;
      if (line_lvl && !last_ff) rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
  end
endmodule : tswd_fault_mon
`default_nettype wire

//--- two_stage_watchdog_timer_tb_top.sv
// Testbench of the two-stage watchdog
`timescale 1ns/1ps
`default_nettype none
module two_stage_watchdog_timer_tb_top import tswd_pkg::*;;
  logic sys_clk, rstn, hard_rstn, clk_en, avs_read, avs_write;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, irq, fault_output_pin, fault_output_pin_oe, line_lvl;
  logic [7:0] rise_cnt;
  int error_cnt = 0;
  int n_compared = 0;
  // Design with a short slow tick of 24 clocks
  tswd_top #(.MS_DIV_P(4)) tswd_top_i (
    .sys_clk(sys_clk), .rstn(rstn), .hard_rstn(hard_rstn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .fault_output_pin(fault_output_pin), .fault_output_pin_oe(fault_output_pin_oe));
  // Board monitor, kept alive across main resets
  tswd_fault_mon tswd_fault_mon_i (
    .sys_clk(sys_clk), .rstn(hard_rstn), .fault_output_pin(fault_output_pin),
    .fault_output_pin_oe(fault_output_pin_oe), .line_lvl(line_lvl), .rise_cnt_ff(rise_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : ck
  // One Avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic busy;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      // Settled mid-cycle values are what the next rising edge samples
      @(negedge sys_clk);
      busy = avs_waitrequest;
      q = avs_readdata;
      @(posedge sys_clk);
    end while (busy !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    ck(nm, q, e);
  endtask : rc
  task automatic unlock();
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY2});
  endtask : unlock
  task automatic t_reset();
    rc("config", OFS_CONFIG, 32'h0);
    rc("lock", OFS_LOCK, 32'h0);
    rc("status", OFS_STATUS, 32'h0);
    rc("unmapped", 6'h3c, 32'h0);
  endtask : t_reset
  task automatic t_unlock();
    wr(OFS_PRELOAD1, 32'h2);
    rc("bare preload", OFS_PRELOAD1, 32'h000fffff);
    unlock();
    wr(OFS_MASK, 32'h3);
    wr(OFS_PRELOAD1, 32'h2);
    rc("broken key", OFS_PRELOAD1, 32'h000fffff);
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
    avs_byteenable <= 4'he;
    wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY2});
    avs_byteenable <= 4'hf;
    wr(OFS_PRELOAD1, 32'h2);
    rc("lane0 off key", OFS_PRELOAD1, 32'h000fffff);
    unlock();
    wr(OFS_PRELOAD1, 32'h2);
    unlock();
    wr(OFS_PRELOAD2, 32'h1);
    rc("preload1", OFS_PRELOAD1, 32'h2);
    rc("preload2", OFS_PRELOAD2, 32'h1);
  endtask : t_unlock
  task automatic t_stages();
    wr(OFS_CONFIG, 32'h24);
    wr(OFS_LOCK, 32'h2);
    for (int i = 0; i < 6; i++) begin
      unlock();
      wr(OFS_KICK, 32'h100);
    end
    ck("irq while kicked", {31'h0, irq}, 32'h0);
    rc("count kicked", OFS_COUNT, 32'h2);
    @(negedge sys_clk);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge sys_clk);
    ck("stage1 irq", {31'h0, irq}, 32'h1);
    ck("line in stage2", {31'h0, line_lvl}, 32'h0);
    @(posedge sys_clk);
    rc("status stage1", OFS_STATUS, 32'h1);
    ck("irq cleared", {31'h0, irq}, 32'h0);
    @(negedge sys_clk);
    for (int i = 0; i < 200 && line_lvl !== 1'b1; i++) @(negedge sys_clk);
    ck("fault line", {31'h0, line_lvl}, 32'h1);
    @(posedge sys_clk);
    rc("status stage2", OFS_STATUS, 32'h6);
    repeat (160) @(posedge sys_clk);
    ck("held line", {31'h0, line_lvl}, 32'h1);
    ck("rises", {24'h0, rise_cnt}, 32'h1);
    wr(OFS_LOCK, 32'h6);
    @(negedge sys_clk);
    for (int i = 0; i < 300 && line_lvl !== 1'b0; i++) @(negedge sys_clk);
    ck("toggled line", {31'h0, line_lvl}, 32'h0);
    for (int i = 0; i < 300 && line_lvl !== 1'b1; i++) @(negedge sys_clk);
    ck("toggled back", {31'h0, line_lvl}, 32'h1);
    @(posedge sys_clk);
    // Fast tick, with a long clock-enable freeze right after the kick
    wr(OFS_CONFIG, 32'h20);
    unlock();
    wr(OFS_KICK, 32'h100);
    clk_en <= 1'b0;
    repeat (300) @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (150) @(posedge sys_clk);
    rc("frozen count", OFS_COUNT, 32'h2);
    repeat (100) @(posedge sys_clk);
    rc("fast tick", OFS_COUNT, 32'h1);
    ck("rises twice", {24'h0, rise_cnt}, 32'h2);
  endtask : t_stages
  task automatic t_lock();
    wr(OFS_LOCK, 32'h3);
    wr(OFS_LOCK, 32'h0);
    rc("locked lock", OFS_LOCK, 32'h3);
    wr(OFS_CONFIG, 32'h0);
    rc("locked config", OFS_CONFIG, 32'h20);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rc("kept flag", OFS_STATUS, 32'h4);
    rstn <= 1'b0;
    hard_rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    hard_rstn <= 1'b1;
    @(posedge sys_clk);
    rc("hard cleared", OFS_STATUS, 32'h0);
  endtask : t_lock
  initial begin
    {rstn, hard_rstn, avs_read, avs_write} = 4'h0;
    clk_en = 1'b1;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    hard_rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_unlock();
    t_stages();
    t_lock();
    conclude();
  end
  // Cuts a hang short
  initial begin
    #40000;
    error_cnt++;
    conclude();
  end
endmodule : two_stage_watchdog_timer_tb_top
`default_nettype wire
